// ===== shared/embi_defines.svh
// Register offsets, field positions and constants of the memory bus block
`ifndef EMBI_DEFINES_SVH
`define EMBI_DEFINES_SVH
`define EMBI_OFF_CTRL_A 8'h00
`define EMBI_OFF_CTRL_B 8'h04
`define EMBI_OFF_AD_OUT 8'h08
`define EMBI_OFF_AD_DIR 8'h0C
`define EMBI_OFF_HI_OUT 8'h10
`define EMBI_OFF_HI_DIR 8'h14
`define EMBI_OFF_STATUS 8'h18
`define EMBI_BIT_EN 7
`define EMBI_LIM_MSB 6
`define EMBI_LIM_LSB 4
`define EMBI_BIT_UP_HI 3
`define EMBI_BIT_UP_LO 2
`define EMBI_BIT_LO_HI 1
`define EMBI_BIT_LO_LO 0
`define EMBI_BIT_KEEP 7
`define EMBI_MASK_MSB 2
`define EMBI_MASK_LSB 0
`define EMBI_RST_BYTE 8'h00
`define EMBI_RST_WORD 32'h0000_0000
`define EMBI_PAD_24 24'h00_0000
`define EMBI_PAD_23 23'h00_0000
`define EMBI_INT_TOP 16'h21FF
`define EMBI_ALL_ONES 8'hFF
`define EMBI_NO_WAIT 2'h0
`define EMBI_WAIT_ONE 2'h1
`define EMBI_LIM_NONE 3'h0
`define EMBI_CNT_ZERO 4'h0
`define EMBI_CNT_ONE 4'h1
`define EMBI_CNT_MAX 4'hF
`define EMBI_STROBE_BASE 4'h2
`define EMBI_TRAIL_BASE 4'h3
`endif

// ===== shared/embi_pkg.sv
// Types shared by the memory bus block
package embi_pkg;
   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_addr = 6'h02,
      st_strobe = 6'h04,
      st_wait = 6'h08,
      st_data = 6'h10,
      st_trail = 6'h20
   } embi_state_type;
endpackage

// ===== verilog/embi_sector.sv
// Sector decode and wait-state selection
`timescale 1ns/1ps
`include "embi_defines.svh"
module embi_sector
   import embi_pkg::*;
(
   input wire logic [2:0] addr_top,
   input wire logic [2:0] sector_limit,
   input wire logic upper_sector_wait_hi,
   input wire logic upper_sector_wait_lo,
   input wire logic lower_sector_wait_hi,
   input wire logic lower_sector_wait_lo,
   output logic [1:0] wait_count
);
   wire in_lower;
   wire sector_wait_sel_hi;
   wire sector_wait_sel_lo;
   assign in_lower = (sector_limit != `EMBI_LIM_NONE) &&
                     (addr_top < sector_limit);
   assign sector_wait_sel_hi = in_lower ? lower_sector_wait_hi
                                        : upper_sector_wait_hi;
   assign sector_wait_sel_lo = in_lower ? lower_sector_wait_lo
                                        : upper_sector_wait_lo;
   assign wait_count = {sector_wait_sel_hi, sector_wait_sel_lo};
endmodule

// ===== verilog/embi_regs.sv
// Wishbone register file of the memory bus block
`timescale 1ns/1ps
`include "embi_defines.svh"
module embi_regs
   import embi_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic busy,
   input wire logic [7:0] last_rdata,
   output logic [7:0] ext_bus_ctrl_a,
   output logic [7:0] ext_bus_ctrl_b,
   output logic [7:0] ad_port_out,
   output logic [7:0] ad_port_dir,
   output logic [7:0] high_addr_port_out,
   output logic [7:0] high_addr_port_dir
);
   wire req;
   wire wr;
   wire [31:0] rd_mux;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign rd_mux =
      (wb_adr_i == `EMBI_OFF_CTRL_A) ? {`EMBI_PAD_24, ext_bus_ctrl_a} :
      (wb_adr_i == `EMBI_OFF_CTRL_B) ? {`EMBI_PAD_24, ext_bus_ctrl_b} :
      (wb_adr_i == `EMBI_OFF_AD_OUT) ? {`EMBI_PAD_24, ad_port_out} :
      (wb_adr_i == `EMBI_OFF_AD_DIR) ? {`EMBI_PAD_24, ad_port_dir} :
      (wb_adr_i == `EMBI_OFF_HI_OUT) ? {`EMBI_PAD_24, high_addr_port_out} :
      (wb_adr_i == `EMBI_OFF_HI_DIR) ? {`EMBI_PAD_24, high_addr_port_dir} :
      (wb_adr_i == `EMBI_OFF_STATUS) ? {`EMBI_PAD_23, busy, last_rdata} :
      `EMBI_RST_WORD;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `EMBI_RST_WORD;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_mux : `EMBI_RST_WORD;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ext_bus_ctrl_a <= `EMBI_RST_BYTE;
         ext_bus_ctrl_b <= `EMBI_RST_BYTE;
         ad_port_out <= `EMBI_RST_BYTE;
         ad_port_dir <= `EMBI_RST_BYTE;
         high_addr_port_out <= `EMBI_RST_BYTE;
         high_addr_port_dir <= `EMBI_RST_BYTE;
      end else if (wr) begin
         if (wb_adr_i == `EMBI_OFF_CTRL_A) ext_bus_ctrl_a <= wb_dat_i[7:0];
         if (wb_adr_i == `EMBI_OFF_CTRL_B) ext_bus_ctrl_b <= wb_dat_i[7:0];
         if (wb_adr_i == `EMBI_OFF_AD_OUT) ad_port_out <= wb_dat_i[7:0];
         if (wb_adr_i == `EMBI_OFF_AD_DIR) ad_port_dir <= wb_dat_i[7:0];
         if (wb_adr_i == `EMBI_OFF_HI_OUT) begin
            high_addr_port_out <= wb_dat_i[7:0];
         end
         if (wb_adr_i == `EMBI_OFF_HI_DIR) begin
            high_addr_port_dir <= wb_dat_i[7:0];
         end
      end
   end
endmodule

// ===== verilog/embi_top.sv
// Multiplexed external memory bus controller, top level
`timescale 1ns/1ps
`include "embi_defines.svh"
module embi_top
   import embi_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cpu_req,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_we,
   input wire logic [7:0] cpu_wdata,
   input wire logic cpu_next_ram,
   output logic cpu_busy,
   output logic cpu_done,
   output logic [7:0] cpu_rdata,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe_n,
   output logic ad_keeper_on,
   output logic [7:0] ad_pullup_en,
   output logic [7:0] high_addr_out,
   output logic [7:0] high_addr_oe_n,
   output logic ale,
   output logic rd_n,
   output logic wr_n
);
   embi_state_type state;
   embi_state_type next_state;
   logic [7:0] ext_bus_ctrl_a;
   logic [7:0] ext_bus_ctrl_b;
   logic [7:0] ad_port_out;
   logic [7:0] ad_port_dir;
   logic [7:0] high_addr_port_out;
   logic [7:0] high_addr_port_dir;
   logic [15:0] acc_addr;
   logic acc_we;
   logic [7:0] acc_wdata;
   logic acc_ext;
   logic [1:0] acc_wait;
   logic [1:0] wait_cnt;
   logic [1:0] sel_wait;
   logic [1:0] exp_wait;

   wire ext_bus_if_en;
   wire [2:0] sector_limit;
   wire keeper_en;
   wire [2:0] high_addr_mask_field;
   wire take;
   wire req_int;
   wire strobe_ph;
   wire next_ad_drive;
   wire [7:0] next_ad_value;
   wire [7:0] next_ad_out;
   wire [7:0] mask_vec;
   wire [7:0] addr_hi;
   wire [7:0] next_high_out;
   wire [7:0] high_drive;
   wire next_rd_n;
   wire next_wr_n;
   wire next_done;
   wire [7:0] next_rdata;
   wire exp_lower;

   assign ext_bus_if_en = ext_bus_ctrl_a[`EMBI_BIT_EN];
   assign sector_limit = ext_bus_ctrl_a[`EMBI_LIM_MSB:`EMBI_LIM_LSB];
   assign keeper_en = ext_bus_ctrl_b[`EMBI_BIT_KEEP];
   assign high_addr_mask_field =
      ext_bus_ctrl_b[`EMBI_MASK_MSB:`EMBI_MASK_LSB];

   embi_regs u_regs (
      .clk(clk),
      .reset(reset),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .busy(cpu_busy),
      .last_rdata(cpu_rdata),
      .ext_bus_ctrl_a(ext_bus_ctrl_a),
      .ext_bus_ctrl_b(ext_bus_ctrl_b),
      .ad_port_out(ad_port_out),
      .ad_port_dir(ad_port_dir),
      .high_addr_port_out(high_addr_port_out),
      .high_addr_port_dir(high_addr_port_dir)
   );

   embi_sector u_sector (
      .addr_top(cpu_addr[15:13]),
      .sector_limit(sector_limit),
      .upper_sector_wait_hi(ext_bus_ctrl_a[`EMBI_BIT_UP_HI]),
      .upper_sector_wait_lo(ext_bus_ctrl_a[`EMBI_BIT_UP_LO]),
      .lower_sector_wait_hi(ext_bus_ctrl_a[`EMBI_BIT_LO_HI]),
      .lower_sector_wait_lo(ext_bus_ctrl_a[`EMBI_BIT_LO_LO]),
      .wait_count(sel_wait)
   );

   assign take = cpu_req && (state == st_idle);
   assign req_int = cpu_addr <= `EMBI_INT_TOP;

   always_comb begin
      next_state = state;
      unique case (state)
         st_idle: begin
            if (take && ext_bus_if_en) next_state = st_addr;
         end
         st_addr: next_state = st_strobe;
         st_strobe: begin
            next_state = (acc_wait != `EMBI_NO_WAIT) ? st_wait : st_data;
         end
         st_wait: begin
            if (wait_cnt == acc_wait) next_state = st_data;
         end
         st_data: next_state = cpu_next_ram ? st_trail : st_idle;
         st_trail: next_state = st_idle;
         default: next_state = st_idle;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= st_idle;
         wait_cnt <= `EMBI_NO_WAIT;
      end else begin
         state <= next_state;
         wait_cnt <= (state == st_wait) ? 2'(wait_cnt + `EMBI_WAIT_ONE)
                                        : `EMBI_WAIT_ONE;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         acc_addr <= {`EMBI_RST_BYTE, `EMBI_RST_BYTE};
         acc_we <= 1'b0;
         acc_wdata <= `EMBI_RST_BYTE;
         acc_ext <= 1'b0;
         acc_wait <= `EMBI_NO_WAIT;
      end else if (take && ext_bus_if_en) begin
         acc_addr <= cpu_addr;
         acc_we <= cpu_we;
         acc_wdata <= cpu_wdata;
         acc_ext <= !req_int;
         acc_wait <= req_int ? `EMBI_NO_WAIT : sel_wait;
      end
   end

   assign strobe_ph = (next_state == st_strobe) ||
                      (next_state == st_wait) || (next_state == st_data);
   assign next_rd_n = !(ext_bus_if_en && acc_ext && !acc_we && strobe_ph);
   assign next_wr_n = !(ext_bus_if_en && acc_ext && acc_we && strobe_ph);

   // address first, then data or release
   assign next_ad_drive = !ext_bus_if_en ? ad_port_dir[0] :
                          (next_state == st_addr) ||
                          (strobe_ph && acc_we);
   assign next_ad_value = !ext_bus_if_en ? ad_port_out :
                          (next_state == st_addr) ? cpu_addr[7:0] :
                          acc_wdata;
   assign next_ad_out = next_ad_drive ? next_ad_value : ad_out;

   // top bits handed back to the port
   assign mask_vec = ~(`EMBI_ALL_ONES >> high_addr_mask_field);
   // upper address byte on high pins
   assign addr_hi = (next_state == st_addr) ? cpu_addr[15:8]
                                            : acc_addr[15:8];
   assign next_high_out = ext_bus_if_en ?
      ((addr_hi & ~mask_vec) | (high_addr_port_out & mask_vec)) :
      high_addr_port_out;
   assign high_drive = ext_bus_if_en ?
      (~mask_vec | (high_addr_port_dir & mask_vec)) : high_addr_port_dir;

   assign next_done = (take && !ext_bus_if_en) || (state == st_data);
   assign next_rdata = (state == st_data && acc_ext && !acc_we) ? ad_in
                                                                : cpu_rdata;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         ad_out <= `EMBI_RST_BYTE;
         ad_oe_n <= 1'b1;
         ad_keeper_on <= 1'b0;
         ad_pullup_en <= `EMBI_RST_BYTE;
      end else begin
         // latch pulse at address and trail
         ale <= (next_state == st_addr) || (next_state == st_trail);
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         ad_out <= next_ad_out;
         ad_oe_n <= !next_ad_drive;
         ad_keeper_on <= keeper_en && !next_ad_drive;
         ad_pullup_en <= ad_port_out;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         high_addr_out <= `EMBI_RST_BYTE;
         high_addr_oe_n <= `EMBI_ALL_ONES;
         cpu_busy <= 1'b0;
         cpu_done <= 1'b0;
         cpu_rdata <= `EMBI_RST_BYTE;
      end else begin
         high_addr_out <= next_high_out;
         high_addr_oe_n <= ~high_drive;
         cpu_busy <= next_state != st_idle;
         cpu_done <= next_done;
         cpu_rdata <= next_rdata;
      end
   end

   // Checking helpers
   logic [3:0] period;
   logic [3:0] strobe_len;
   assign exp_lower = (sector_limit != `EMBI_LIM_NONE) &&
                      (acc_addr[15:13] < sector_limit);
   assign exp_wait = exp_lower ?
      {ext_bus_ctrl_a[`EMBI_BIT_LO_HI], ext_bus_ctrl_a[`EMBI_BIT_LO_LO]} :
      {ext_bus_ctrl_a[`EMBI_BIT_UP_HI], ext_bus_ctrl_a[`EMBI_BIT_UP_LO]};

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         period <= `EMBI_CNT_ZERO;
         strobe_len <= `EMBI_CNT_ZERO;
      end else begin
         if (next_state == st_addr) period <= `EMBI_CNT_ZERO;
         else if (period != `EMBI_CNT_MAX) begin
            period <= 4'(period + `EMBI_CNT_ONE);
         end
         strobe_len <= (!rd_n || !wr_n) ? 4'(strobe_len + `EMBI_CNT_ONE)
                                       : `EMBI_CNT_ZERO;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence seq_quiet;
      (rd_n && wr_n) [*4];
   endsequence

   sequence seq_strobe_end;
      $rose(rd_n && wr_n);
   endsequence

   a_strobe_length: assert property (
      seq_strobe_end |->
         strobe_len == 4'(`EMBI_STROBE_BASE + {2'b00, exp_wait}))
      else $error("strobe length differs from wait setting");

   a_trail_period: assert property (
      $rose(ale) && state == st_trail |->
         period == 4'(`EMBI_TRAIL_BASE +
                      {2'b00, acc_ext ? exp_wait : `EMBI_NO_WAIT}))
      else $error("trailing latch pulse in wrong period");

   a_trail_ram_only: assert property (
      state == st_trail |-> $past(cpu_next_ram))
      else $error("trailing pulse without following ram access");

   a_internal_quiet: assert property (
      take && req_int |=> seq_quiet)
      else $error("strobe issued for internal address");

   a_int_no_strobe: assert property (
      !acc_ext && state != st_idle |-> rd_n && wr_n)
      else $error("strobe toggled during internal access");

   a_addr_at_fall: assert property (
      $fell(ale) && state == st_strobe |->
         $past(ad_oe_n) == 1'b0 && $past(ad_out) == acc_addr[7:0])
      else $error("low address not valid at latch fall");

   a_ale_low_xfer: assert property (
      (state == st_strobe || state == st_wait || state == st_data)
         |-> !ale)
      else $error("latch strobe high during transfer");

   a_mask_port: assert property (
      1'b1 |=> ((high_addr_out ^ $past(high_addr_port_out)) &
                $past(mask_vec)) == `EMBI_RST_BYTE)
      else $error("masked high pin not from port register");

   a_high_hold: assert property (
      ext_bus_if_en && (state == st_strobe || state == st_data) |->
         ((high_addr_out ^ acc_addr[15:8]) & ~mask_vec) == `EMBI_RST_BYTE)
      else $error("high address byte not held");

   a_keeper_hold: assert property (
      ad_oe_n |-> $stable(ad_out))
      else $error("released lines lost their last value");

   a_dir_follow: assert property (
      !ext_bus_if_en |=> high_addr_oe_n == ~$past(high_addr_port_dir))
      else $error("disabled high pins ignore port direction");

   a_pullup_map: assert property (
      1'b1 |=> ad_pullup_en == $past(ad_port_out))
      else $error("pull-up enable differs from port register");
endmodule

// ===== testbench/embi_sram_model.sv
// Asynchronous external memory behind a transparent address latch
`timescale 1ns/1ps
module embi_sram_model
   import embi_pkg::*;
(
   input wire logic [7:0] ad_out,
   input wire logic ad_oe_n,
   input wire logic ad_keeper_on,
   input wire logic [7:0] ad_pullup_en,
   input wire logic [7:0] high_addr_out,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [7:0] ad_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] low_addr;
   logic [7:0] last_level;
   wire [7:0] ad_held;
   wire [7:0] hi_held;
   wire [15:0] mem_addr;
   // Pins settle 1 ns late, which models the latch hold time
   assign #1 ad_held = ad_out;
   assign #1 hi_held = high_addr_out;
   assign mem_addr = {hi_held, low_addr};
   always_latch begin
      if (ale) begin
         low_addr <= ad_held;
      end
   end
   always @(wr_n, ad_oe_n, ad_out, mem_addr) begin
      if (!wr_n && !ad_oe_n) begin
         mem[mem_addr] = ad_out;
      end
   end
   // Last level seen on the wire
   always @(ad_oe_n, rd_n, ad_out, mem_addr) begin
      if (!ad_oe_n) begin
         last_level = ad_out;
      end else if (!rd_n) begin
         last_level = mem[mem_addr];
      end
   end
   // A released wire drifts away from its last level unless held
   assign ad_in = !ad_oe_n ? ad_out : !rd_n ? mem[mem_addr] :
      ad_keeper_on ? last_level : (ad_pullup_en | ~last_level);
endmodule

// ===== testbench/embi_top_tb.sv
// Self-checking bench of the multiplexed memory bus controller
`timescale 1ns/1ps
`include "embi_defines.svh"
module embi_top_tb
   import embi_pkg::*;
;
   logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd32;
   logic cpu_req, cpu_we, cpu_next_ram, cpu_busy, cpu_done;
   logic [15:0] cpu_addr;
   logic [7:0] cpu_wdata, cpu_rdata, ad_in, ad_out, ad_pullup_en;
   logic [7:0] high_addr_out, high_addr_oe_n, hi1;
   logic ad_oe_n, ad_keeper_on, ale, rd_n, wr_n, trail;
   int err_count, check_count, lat, low_cnt;

   embi_top uut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
      .cpu_we(cpu_we), .cpu_wdata(cpu_wdata), .cpu_next_ram(cpu_next_ram),
      .cpu_busy(cpu_busy), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
      .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
      .ad_keeper_on(ad_keeper_on), .ad_pullup_en(ad_pullup_en),
      .high_addr_out(high_addr_out), .high_addr_oe_n(high_addr_oe_n),
      .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
   embi_sram_model mem_model (.ad_out(ad_out), .ad_oe_n(ad_oe_n),
      .ad_keeper_on(ad_keeper_on), .ad_pullup_en(ad_pullup_en),
      .high_addr_out(high_addr_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .ad_in(ad_in));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check_byte(input string n, input logic [7:0] e,
         input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic check_num(input string n, input int e, input int s);
      check_count++;
      if (s != e) begin
         err_count++;
         $display("mismatch %s expected %0d seen %0d", n, e, s);
      end
   endtask

   task automatic wb_cycle(input logic we, input logic [7:0] adr,
         input logic [3:0] sel, input logic [7:0] dat);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= {24'h00_0000, dat};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      rd32 = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wb_wr(input logic [7:0] adr, input logic [7:0] dat);
      wb_cycle(1'b1, adr, 4'hF, dat);
   endtask

   // One processor access, timed from the edge that takes it
   task automatic cpu_acc(input logic [15:0] a, input logic we,
         input logic [7:0] d, input logic nr);
      @(posedge clk);
      cpu_req <= 1'b1;
      cpu_addr <= a;
      cpu_we <= we;
      cpu_wdata <= d;
      cpu_next_ram <= nr;
      @(posedge clk);
      cpu_req <= 1'b0;
      lat = 0;
      low_cnt = 0;
      do begin
         if (lat > 0) @(posedge clk);
         #1;
         lat++;
         if (lat == 2) hi1 = high_addr_out;
         if (rd_n === 1'b0 || wr_n === 1'b0) low_cnt++;
         trail = ale;
      end while (cpu_done !== 1'b1);
      while (cpu_busy !== 1'b0) begin
         @(posedge clk);
         #1;
      end
   endtask

   initial begin
      #100000;
      err_count++;
      print_verdict();
   end

   initial begin
      reset = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, cpu_req, cpu_we, cpu_next_ram} = 6'h00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      cpu_addr = 16'h0000;
      cpu_wdata = 8'h00;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      #1;
      check_byte("strobes", 8'h03, {6'h00, rd_n, wr_n});
      check_byte("high oe", 8'hFF, high_addr_oe_n); // port direction
      // Refused accesses
      wb_cycle(1'b0, 8'h1C, 4'hF, 8'h00);
      check_byte("unmapped", 8'h00, rd32[7:0]);
      wb_cycle(1'b1, `EMBI_OFF_HI_OUT, 4'hE, 8'hFF);
      wb_cycle(1'b0, `EMBI_OFF_HI_OUT, 4'hF, 8'h00);
      check_byte("sel0 write", 8'h00, rd32[7:0]);
      // Disabled block
      wb_wr(`EMBI_OFF_HI_OUT, 8'h5A);
      wb_wr(`EMBI_OFF_HI_DIR, 8'h0F);
      #1;
      check_byte("port out", 8'h5A, high_addr_out); // port value
      check_byte("port oe", 8'hF0, high_addr_oe_n); // port direction
      wb_cycle(1'b0, `EMBI_OFF_HI_DIR, 4'hF, 8'h00); // direction read
      check_byte("dir readback", 8'h0F, rd32[7:0]); // port direction
      cpu_acc(16'h4000, 1'b1, 8'h11, 1'b0);
      check_num("off latency", 1, lat); // no bus cycle
      check_num("off strobes", 0, low_cnt); // no strobes
      wb_wr(`EMBI_OFF_AD_DIR, 8'h01); // port direction
      wb_wr(`EMBI_OFF_AD_OUT, 8'hA5);
      @(posedge clk);
      #1;
      check_byte("pullups", 8'hA5, ad_pullup_en); // pull-up per bit
      check_byte("ad port", 8'hA5, ad_out); // port value
      check_byte("ad oe", 8'h00, {7'h00, ad_oe_n}); // port direction
      wb_wr(`EMBI_OFF_AD_OUT, 8'h00); // pull-ups off for sleep
      @(posedge clk);
      #1;
      check_byte("pullups off", 8'h00, ad_pullup_en); // pull-up per bit
      // All four wait settings, one sector
      for (int w = 0; w < 4; w++) begin
         wb_wr(`EMBI_OFF_CTRL_A, 8'h80 | 8'(w << 2));
         cpu_acc(16'h4000 + 16'(w), 1'b1, 8'h10 + 8'(w), w[0]);
         check_num("wr latency", 4 + w, lat); // wait length
         check_num("wr strobe", 2 + w, low_cnt); // strobe length
         check_byte("trail", 8'(w[0]), 8'(trail));
         cpu_acc(16'h4000 + 16'(w), 1'b0, 8'h00, ~w[0]);
         check_num("rd strobe", 2 + w, low_cnt); // strobe length
         check_byte("trail", 8'(!w[0]), 8'(trail));
         check_byte("high byte", 8'h40, hi1); // upper address
         check_byte("rdata", 8'h10 + 8'(w), cpu_rdata); // latched addr
      end
      // Two sectors split at limit 4, waits swapped
      for (int s = 0; s < 2; s++) begin
         wb_wr(`EMBI_OFF_CTRL_A, s ? 8'hCC : 8'hC3);
         cpu_acc(16'h3000, 1'b1, 8'h66, 1'b0);
         check_num("lower sector", s ? 4 : 7, lat); // lower waits
         cpu_acc(16'hC000, 1'b1, 8'h99, 1'b0);
         check_num("upper sector", s ? 7 : 4, lat); // upper waits
      end
      // Internal boundary
      wb_wr(`EMBI_OFF_CTRL_A, 8'h80);
      cpu_acc(16'h21FF, 1'b0, 8'h00, 1'b0);
      check_num("int strobe", 0, low_cnt); // no strobes
      check_num("int latency", 4, lat); // same pin cycle
      cpu_acc(16'h2200, 1'b1, 8'hE1, 1'b0);
      check_num("ext strobe", 2, low_cnt); // first external
      cpu_acc(16'h2200, 1'b0, 8'h00, 1'b0);
      check_byte("ext rdata", 8'hE1, cpu_rdata); // reachable
      wb_cycle(1'b0, `EMBI_OFF_STATUS, 4'hF, 8'h00); // last read
      check_byte("status rdata", 8'hE1, rd32[7:0]); // reachable
      check_byte("status busy", 8'h00, {7'h00, rd32[8]}); // idle
      // Masked high pins
      wb_wr(`EMBI_OFF_HI_OUT, 8'h00);
      wb_wr(`EMBI_OFF_HI_DIR, 8'hFF);
      wb_wr(`EMBI_OFF_CTRL_B, 8'h02);
      cpu_acc(16'hC123, 1'b1, 8'h3C, 1'b0);
      check_byte("masked high", 8'h01, hi1); // port bits
      wb_wr(`EMBI_OFF_CTRL_B, 8'h00);
      cpu_acc(16'hC123, 1'b1, 8'h77, 1'b0);
      check_byte("full high", 8'hC1, hi1); // upper address
      wb_wr(`EMBI_OFF_CTRL_B, 8'h02);
      cpu_acc(16'hC123, 1'b0, 8'h00, 1'b0);
      check_byte("masked rdata", 8'h3C, cpu_rdata); // masked location
      // Bus keeper
      wb_wr(`EMBI_OFF_CTRL_B, 8'h80);
      cpu_acc(16'h4001, 1'b0, 8'h00, 1'b0);
      check_byte("keeper", 8'h03, {6'h00, ad_keeper_on, ad_oe_n});
      wb_wr(`EMBI_OFF_CTRL_B, 8'h00);
      @(posedge clk);
      #1;
      check_byte("keeper off", 8'h01, {6'h00, ad_keeper_on, ad_oe_n});
      print_verdict();
   end
endmodule
